// ---- core/timer_buffer_event_irq_ctrl.v ----
// Timer control and status: direction, buffer-valid flags, events, interrupts, debug, byte latch
//
// Contract
// - Direction bit 0 counts up, 1 counts down; hardware and software both change it.
// - Writing one to buffer-valid clear register clears that bit only.
// - Writing one to buffer-valid set register sets that bit only.
// - Compare buffer valid sets on buffer write, clears on update condition.
// - Period buffer valid sets on buffer write, clears on update condition.
// - Event action 0 counts rising edges, action 1 counts both edges.
// - Action 2 counts ticks while line high; action 3 line sets direction.
// - Event count enable 0 ignores event line, 1 counts per action.
// - Interrupt enable bits 4 to 6 allow compare channel interrupts.
// - Interrupt enable bit 0 allows wrap interrupt while wrap flag set.
// - Compare flag sets while the timer runs and counter equals channel compare value.
// - Compare flag stays set until software writes one to it.
// - Wrap flag sets at top or bottom as waveform mode selects.
// - Wrap flag stays set until software writes one to bit 0.
// - Run-during-break 0 halts timer and ignores events in break.
// - One shared byte latch serves 16-bit access, also directly readable/writable.
// - Hold-buffer-loading 1 blocks buffered loads on update condition.
// - 16-bit register low byte at base, high byte at base plus one.
`include "timer_ctrl_map.vh"
`timescale 1ns/10ps
`default_nettype none
module timer_buffer_event_irq_ctrl (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Timer context
  input wire timer_enable,
  input wire prescale_tick,
  input wire [2:0] waveform_mode,
  input wire update_request,
  input wire debug_break,
  // Event line
  input wire event_line,
  // Interrupt requests
  output wire wrap_irq,
  output wire [2:0] compare_irq,
  // Timer state
  output reg [15:0] count_reg,
  output reg [15:0] period_reg,
  output wire [47:0] compare_values,
  output wire at_top,
  output wire at_bottom,
  output wire update_event
);
  reg dir_reg;
  reg hold_reg;
  reg period_valid_reg;
  reg [15:0] period_buf_reg;
  reg [2:0] event_ctrl_reg;
  reg [7:0] int_enable_reg;
  reg wrap_flag_reg;
  reg run_during_break_reg;
  reg [7:0] latch_reg;
  reg [15:0] wide_rd;
  reg [15:0] count_next;
  reg event_meta_reg;
  reg event_sync_reg;
  reg event_prev_reg;
  wire [15:0] cmp_buf0, cmp_buf1, cmp_buf2;
  wire [15:0] cmp0, cmp1, cmp2;
  wire [2:0] cmp_valid;
  wire [2:0] cmp_flag;
  wire running = timer_enable && (!debug_break || run_during_break_reg);
  wire [7:0] base = {reg_addr[7:1], 1'b0};
  wire is_high = reg_addr[0];
  // Only the mapped pairs touch the latch; the gaps in the wide range stay unmapped
  wire wide_hit = base == `OFS_CNT || base == `OFS_PER || base == `OFS_PERIOD_BUFFER ||
    base == `OFS_CMP0 || base == `OFS_CMP1 || base == `OFS_CMP2 ||
    base == `OFS_CMPBUF0 || base == `OFS_CMPBUF1 || base == `OFS_CMPBUF2;
  wire wide_low_write = reg_write && !is_high;
  wire [15:0] wide_data = {latch_reg, reg_wdata};
  wire wr_count = wide_low_write && base == `OFS_CNT;
  wire wr_period = wide_low_write && base == `OFS_PER;
  wire wr_period_buffer = wide_low_write && base == `OFS_PERIOD_BUFFER;
  wire [2:0] wr_cmp;
  wire [2:0] wr_cmpbuf;
  wire bv_clear_wr = reg_write && reg_addr == `OFS_BV_CLEAR;
  wire bv_set_wr = reg_write && reg_addr == `OFS_BV_SET;
  wire flags_wr = reg_write && reg_addr == `OFS_INT_FLAGS;
  wire [1:0] act = event_ctrl_reg[`EV_ACT_LSB +: 2];
  wire ev_on = event_ctrl_reg[`EV_COUNT_EN_BIT] && running;
  wire ev_rise = event_sync_reg && !event_prev_reg;
  wire ev_edge = event_sync_reg != event_prev_reg;
  reg step;
  reg step_down;
  always @* begin
    step = 1'b0;
    step_down = dir_reg;
    if (!running) begin
      step = 1'b0;
    end else if (!event_ctrl_reg[`EV_COUNT_EN_BIT]) begin
      step = prescale_tick;
    end else begin
      case (act)
        `ACT_RISING: step = ev_rise;
        `ACT_BOTH: step = ev_edge;
        `ACT_HIGH: step = prescale_tick && event_sync_reg;
        `ACT_UPDOWN: begin
          step = prescale_tick;
          step_down = event_sync_reg;
        end
        default: step = 1'b0;
      endcase
    end
  end
  wire dual = waveform_mode == `WG_DS_TOP || waveform_mode == `WG_DS_BOTH || waveform_mode == `WG_DS_BOTTOM;
  wire [15:0] top_value = (waveform_mode == `WG_FREQ) ? cmp0 : period_reg;
  assign at_top = step && !step_down && count_reg >= top_value;
  assign at_bottom = step && step_down && count_reg == 16'h0000;
  // Next count at a step: wrap, turn or move one
  always @* begin
    count_next = count_reg;
    if (!step_down && count_reg >= top_value) begin
      count_next = dual ? top_value - 16'h0001 : `CNT_RESET;
    end else if (step_down && count_reg == `CNT_RESET) begin
      count_next = dual ? 16'h0001 : top_value;
    end else if (step_down) begin
      count_next = count_reg - 16'h0001;
    end else begin
      count_next = count_reg + 16'h0001;
    end
  end
  reg wrap_hit;
  reg update_hit;
  always @* begin
    wrap_hit = 1'b0;
    update_hit = 1'b0;
    case (waveform_mode)
      `WG_NORMAL, `WG_FREQ: begin
        wrap_hit = at_top || at_bottom;
        update_hit = at_top || at_bottom;
      end
      `WG_SINGLE: begin
        wrap_hit = at_bottom || at_top;
        update_hit = at_bottom || at_top;
      end
      `WG_DS_TOP: begin
        wrap_hit = at_top;
        update_hit = at_bottom;
      end
      `WG_DS_BOTH: begin
        wrap_hit = at_top || at_bottom;
        update_hit = at_bottom;
      end
      `WG_DS_BOTTOM: begin
        wrap_hit = at_bottom;
        update_hit = at_bottom;
      end
      default: begin
        wrap_hit = 1'b0;
        update_hit = 1'b0;
      end
    endcase
  end
  assign update_event = update_hit || update_request;
  wire load_update = update_event && !hold_reg;
  // Event line synchroniser and edge history
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      event_meta_reg <= 1'b0;
      event_sync_reg <= 1'b0;
      event_prev_reg <= 1'b0;
    end else begin
      event_meta_reg <= event_line;
      event_sync_reg <= event_meta_reg;
      event_prev_reg <= event_sync_reg;
    end
  end
  // Control and status registers
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dir_reg <= 1'b0;
      hold_reg <= 1'b0;
      period_valid_reg <= 1'b0;
      event_ctrl_reg <= 3'h0;
      int_enable_reg <= 8'h00;
      wrap_flag_reg <= 1'b0;
      run_during_break_reg <= 1'b0;
    end else begin
      if (reg_write && reg_addr == `OFS_DIR_CLEAR) begin
        if (reg_wdata[`CTRLE_DIR_BIT]) begin
          dir_reg <= 1'b0;
        end
        if (reg_wdata[`CTRLE_HOLD_BIT]) begin
          hold_reg <= 1'b0;
        end
      end else if (reg_write && reg_addr == `OFS_DIR_SET) begin
        if (reg_wdata[`CTRLE_DIR_BIT]) begin
          dir_reg <= 1'b1;
        end
        if (reg_wdata[`CTRLE_HOLD_BIT]) begin
          hold_reg <= 1'b1;
        end
      end else if (step && ev_on && act == `ACT_UPDOWN) begin
        dir_reg <= event_sync_reg;
      end else if (step && dual && at_top) begin
        dir_reg <= 1'b1;
      end else if (step && dual && at_bottom) begin
        dir_reg <= 1'b0;
      end
      if (wr_period_buffer || (bv_set_wr && reg_wdata[`BV_PER_BIT])) begin
        period_valid_reg <= 1'b1;
      end else if ((bv_clear_wr && reg_wdata[`BV_PER_BIT]) || load_update) begin
        period_valid_reg <= 1'b0;
      end
      if (reg_write && reg_addr == `OFS_EVENT_CTRL) begin
        event_ctrl_reg <= reg_wdata[2:0];
      end
      if (reg_write && reg_addr == `OFS_INT_ENABLE) begin
        int_enable_reg <= reg_wdata & `INT_ENABLE_MASK;
      end
      if (reg_write && reg_addr == `OFS_DEBUG_CTRL) begin
        run_during_break_reg <= reg_wdata[`DBG_RUN_BIT];
      end
      if (wrap_hit) begin
        wrap_flag_reg <= 1'b1;
      end else if (flags_wr && reg_wdata[`INT_WRAP_BIT]) begin
        wrap_flag_reg <= 1'b0;
      end
    end
  end
  // Counter, period and period buffer
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_reg <= `CNT_RESET;
      period_reg <= `PER_RESET;
      period_buf_reg <= `PER_RESET;
    end else begin
      if (wr_count) begin
        count_reg <= wide_data;
      end else if (step) begin
        count_reg <= count_next;
      end
      if (wr_period_buffer) begin
        period_buf_reg <= wide_data;
      end
      if (wr_period) begin
        period_reg <= wide_data;
      end else if (load_update && period_valid_reg) begin
        period_reg <= period_buf_reg;
      end
    end
  end
  // Shared byte latch
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      latch_reg <= 8'h00;
    end else if (reg_write && (reg_addr == `OFS_BYTE_LATCH || (is_high && wide_hit))) begin
      latch_reg <= reg_wdata;
    end else if (reg_read && !is_high && wide_hit) begin
      latch_reg <= wide_rd[15:8];
    end
  end
  always @* begin
    case (base)
      `OFS_CNT: wide_rd = count_reg;
      `OFS_PER: wide_rd = period_reg;
      `OFS_CMP0: wide_rd = cmp0;
      `OFS_CMP1: wide_rd = cmp1;
      `OFS_CMP2: wide_rd = cmp2;
      `OFS_PERIOD_BUFFER: wide_rd = period_buf_reg;
      `OFS_CMPBUF0: wide_rd = cmp_buf0;
      `OFS_CMPBUF1: wide_rd = cmp_buf1;
      `OFS_CMPBUF2: wide_rd = cmp_buf2;
      default: wide_rd = 16'h0000;
    endcase
  end
  // Read data register
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `OFS_DIR_CLEAR, `OFS_DIR_SET: reg_rdata <= {6'h00, hold_reg, dir_reg};
        `OFS_BV_CLEAR, `OFS_BV_SET: reg_rdata <= {4'h0, cmp_valid, period_valid_reg};
        `OFS_EVENT_CTRL: reg_rdata <= {5'h00, event_ctrl_reg};
        `OFS_INT_ENABLE: reg_rdata <= int_enable_reg;
        `OFS_INT_FLAGS: reg_rdata <= {1'b0, cmp_flag, 3'h0, wrap_flag_reg};
        `OFS_DEBUG_CTRL: reg_rdata <= {7'h00, run_during_break_reg};
        `OFS_BYTE_LATCH: reg_rdata <= latch_reg;
        default: reg_rdata <= wide_hit ? (is_high ? latch_reg : wide_rd[7:0]) : 8'h00;
      endcase
    end
  end
  // Compare channels
  wire [7:0] cmp_base [0:2];
  wire [7:0] cbuf_base [0:2];
  assign cmp_base[0] = `OFS_CMP0;
  assign cmp_base[1] = `OFS_CMP1;
  assign cmp_base[2] = `OFS_CMP2;
  assign cbuf_base[0] = `OFS_CMPBUF0;
  assign cbuf_base[1] = `OFS_CMPBUF1;
  assign cbuf_base[2] = `OFS_CMPBUF2;
  wire [47:0] bufs;
  wire [47:0] cmps;
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : chan
      assign wr_cmp[i] = wide_low_write && base == cmp_base[i];
      assign wr_cmpbuf[i] = wide_low_write && base == cbuf_base[i];
      compare_channel u_ch (
        .core_clk(core_clk),
        .rst(rst),
        .buf_write(wr_cmpbuf[i]),
        .buf_data(wide_data),
        .bv_set(bv_set_wr && reg_wdata[`BV_CMP_LSB + i]),
        .bv_clear(bv_clear_wr && reg_wdata[`BV_CMP_LSB + i]),
        .cmp_write(wr_cmp[i]),
        .cmp_data(wide_data),
        .load_update(load_update),
        .clear_on_update(load_update),
        .count(count_reg),
        .count_step(running),
        .flag_clear(flags_wr && reg_wdata[`INT_CMP_LSB + i]),
        .buf_reg(bufs[16*i +: 16]),
        .cmp_reg(cmps[16*i +: 16]),
        .valid_reg(cmp_valid[i]),
        .flag_reg(cmp_flag[i])
      );
    end
  endgenerate
  assign cmp_buf0 = bufs[15:0];
  assign cmp_buf1 = bufs[31:16];
  assign cmp_buf2 = bufs[47:32];
  assign cmp0 = cmps[15:0];
  assign cmp1 = cmps[31:16];
  assign cmp2 = cmps[47:32];
  assign compare_values = cmps;
  assign wrap_irq = wrap_flag_reg && int_enable_reg[`INT_WRAP_BIT];
  assign compare_irq = cmp_flag & int_enable_reg[`INT_CMP_LSB +: 3];
endmodule // timer_buffer_event_irq_ctrl
`default_nettype wire

// ---- core/timer_ctrl_map.vh ----
// Register offsets, field positions and codes for the timer control block
`ifndef TIMER_CTRL_MAP_VH
`define TIMER_CTRL_MAP_VH
`define OFS_DIR_CLEAR 8'h04
`define OFS_DIR_SET 8'h05
`define OFS_BV_CLEAR 8'h06
`define OFS_BV_SET 8'h07
`define OFS_EVENT_CTRL 8'h09
`define OFS_INT_ENABLE 8'h0a
`define OFS_INT_FLAGS 8'h0b
`define OFS_DEBUG_CTRL 8'h0e
`define OFS_BYTE_LATCH 8'h0f
`define OFS_CNT 8'h20
`define OFS_PER 8'h26
`define OFS_CMP0 8'h28
`define OFS_CMP1 8'h2a
`define OFS_CMP2 8'h2c
`define OFS_PERIOD_BUFFER 8'h36
`define OFS_CMPBUF0 8'h38
`define OFS_CMPBUF1 8'h3a
`define OFS_CMPBUF2 8'h3c
`define HIGH_BYTE_OFS 8'h01
`define CTRLE_DIR_BIT 0
`define CTRLE_HOLD_BIT 1
`define BV_PER_BIT 0
`define BV_CMP_LSB 1
`define EV_COUNT_EN_BIT 0
`define EV_ACT_LSB 1
`define INT_WRAP_BIT 0
`define INT_CMP_LSB 4
`define DBG_RUN_BIT 0
`define ACT_RISING 2'h0
`define ACT_BOTH 2'h1
`define ACT_HIGH 2'h2
`define ACT_UPDOWN 2'h3
`define WG_NORMAL 3'h0
`define WG_FREQ 3'h1
`define WG_SINGLE 3'h3
`define WG_DS_TOP 3'h5
`define WG_DS_BOTH 3'h6
`define WG_DS_BOTTOM 3'h7
`define PER_RESET 16'hffff
`define CMP_RESET 16'h0000
`define CNT_RESET 16'h0000
`define INT_ENABLE_MASK 8'h71
`endif

// ---- core/compare_channel.v ----
// One compare channel: buffered compare value, buffer-valid bit and sticky match flag
`timescale 1ns/10ps
`default_nettype none
`include "timer_ctrl_map.vh"
module compare_channel (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Buffer access
  input wire buf_write,
  input wire [15:0] buf_data,
  input wire bv_set,
  input wire bv_clear,
  input wire cmp_write,
  input wire [15:0] cmp_data,
  // Update and match
  input wire load_update,
  input wire clear_on_update,
  input wire [15:0] count,
  input wire count_step,
  input wire flag_clear,
  // State
  output reg [15:0] buf_reg,
  output reg [15:0] cmp_reg,
  output reg valid_reg,
  output reg flag_reg
);
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      buf_reg <= `CMP_RESET;
      cmp_reg <= `CMP_RESET;
      valid_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      if (buf_write) begin
        buf_reg <= buf_data;
      end
      if (cmp_write) begin
        cmp_reg <= cmp_data;
      end else if (load_update && valid_reg) begin
        cmp_reg <= buf_reg;
      end
      if (buf_write || bv_set) begin
        valid_reg <= 1'b1;
      end else if (bv_clear || clear_on_update) begin
        valid_reg <= 1'b0;
      end
      if (count_step && count == cmp_reg) begin
        flag_reg <= 1'b1;
      end else if (flag_clear) begin
        flag_reg <= 1'b0;
      end
    end
  end
endmodule // compare_channel
`default_nettype wire

// ---- verification/timer_ctrl_checker_assertions.sv ----
// Concurrent checks on the timer control block ports
`timescale 1ns/10ps
`default_nettype none
module timer_ctrl_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Timer context and state
  input wire logic prescale_tick,
  input wire logic update_request,
  input wire logic debug_break,
  input wire logic update_event,
  input wire logic at_top,
  input wire logic at_bottom,
  input wire logic wrap_irq,
  input wire logic [2:0] compare_irq,
  input wire logic [15:0] count_reg,
  input wire logic [15:0] period_reg
);
  logic [7:0] ie_q;
  logic ev_en_q;
  logic run_q;
  logic flag_wr;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  assign flag_wr = reg_write && (reg_addr == 8'h0a || reg_addr == 8'h0b);
  // Mirrors of software-written controls
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ie_q <= 8'h00;
      ev_en_q <= 1'b0;
      run_q <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == 8'h0a) ie_q <= reg_wdata;
      if (reg_addr == 8'h09) ev_en_q <= reg_wdata[0];
      if (reg_addr == 8'h0e) run_q <= reg_wdata[0];
    end
  end
  sequence s_wr(a);
    reg_write && reg_addr == a;
  endsequence
  sequence s_latch_rd;
    reg_read && !reg_write && reg_addr == 8'h0f;
  endsequence
  sequence s_period_lo;
    s_wr(8'h26) ##0 !update_event;
  endsequence
  a_wrap_irq_gate: assert property (wrap_irq |-> ie_q[0])
    else $error("wrap request while disabled");
  a_cmp_irq_gate: assert property ((compare_irq & ~ie_q[6:4]) == 3'h0)
    else $error("compare request while disabled");
  a_wrap_stays_set: assert property (wrap_irq && !flag_wr |=> wrap_irq)
    else $error("wrap flag dropped by itself");
  a_cmp_stays_set: assert property (compare_irq[0] && !flag_wr |=> compare_irq[0])
    else $error("compare flag dropped by itself");
  a_latch_read_back: assert property (s_wr(8'h0f) ##1 s_latch_rd |=> reg_rdata == $past(reg_wdata, 2))
    else $error("byte latch read wrong");
  a_period_pair: assert property (s_wr(8'h27) ##1 s_period_lo |=> period_reg == {$past(reg_wdata, 2), $past(reg_wdata)})
    else $error("period pair commit wrong");
  a_break_halts: assert property (debug_break && !run_q && !reg_write && !update_request |=> $stable(count_reg))
    else $error("counter moved in break");
  a_events_ignored: assert property (!ev_en_q && !prescale_tick && !reg_write && !update_request |=> $stable(count_reg))
    else $error("counter moved without cause");
  a_forced_update: assert property (update_request |-> update_event)
    else $error("forced update not seen");
  a_bottom_at_zero: assert property (at_bottom |-> count_reg == 16'h0000)
    else $error("bottom away from zero");
  a_ends_in_break: assert property (at_top || at_bottom |-> !debug_break || run_q)
    else $error("end point reached in break");
endmodule // timer_ctrl_checker
bind timer_buffer_event_irq_ctrl timer_ctrl_checker timer_ctrl_checker_i (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .prescale_tick(prescale_tick), .update_request(update_request), .debug_break(debug_break),
  .update_event(update_event), .at_top(at_top), .at_bottom(at_bottom),
  .wrap_irq(wrap_irq), .compare_irq(compare_irq),
  .count_reg(count_reg), .period_reg(period_reg)
);
`default_nettype wire

// ---- verification/event_channel_model.sv ----
// Event channel model feeding the timer event input
`timescale 1ns/10ps
`default_nettype none
module event_channel_model (
  // Clock
  input wire logic core_clk,
  // Requested and delivered level
  input wire logic level_req,
  output logic event_line
);
  // Level arrives late and off the clock edge
  always @(posedge core_clk) event_line <= #7 level_req;
endmodule // event_channel_model
`default_nettype wire

// ---- verification/timer_buffer_event_irq_ctrl_tb_top.sv ----
// Self-checking testbench for the timer control block
`timescale 1ns/10ps
`default_nettype none
module timer_buffer_event_irq_ctrl_tb_top;
  logic core_clk, rst, reg_write, reg_read, timer_enable, prescale_tick;
  logic update_request, debug_break, level_req, event_line, wrap_irq;
  logic at_top, at_bottom, update_event;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] waveform_mode, compare_irq;
  logic [15:0] count_reg, period_reg, cnt;
  logic [47:0] compare_values;
  logic [7:0] ofs [7] = '{8'h06, 8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0e, 8'h0f};
  // Event rows: control, line level, tick, signed step
  logic [7:0] row [10] = '{8'h10, 8'h00, 8'h31, 8'h20, 8'h71, 8'h61, 8'ha8, 8'hb9, 8'hfb, 8'he9};
  int mismatches, check_count;
  timer_buffer_event_irq_ctrl timer_buffer_event_irq_ctrl_i (
    .core_clk, .rst, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata,
    .timer_enable, .prescale_tick, .waveform_mode, .update_request, .debug_break,
    .event_line, .wrap_irq, .compare_irq, .count_reg, .period_reg, .compare_values,
    .at_top, .at_bottom, .update_event
  );
  event_channel_model event_channel_model_i (.core_clk, .level_req, .event_line);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic strobe(input logic t, input logic u);
    @(posedge core_clk);
    reg_write <= 1'b0;
    prescale_tick <= t;
    update_request <= u;
    @(posedge core_clk);
    prescale_tick <= 1'b0;
    update_request <= 1'b0;
    #1;
  endtask
  task automatic setcnt(input logic [15:0] v);
    wr(8'h21, v[15:8]);
    wr(8'h20, v[7:0]);
    strobe(1'b0, 1'b0);
    cnt = v;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Whole run takes under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    tally_and_finish;
  end
  initial begin
    {reg_write, reg_read, timer_enable, prescale_tick} = 4'h0;
    {update_request, debug_break, level_req} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    waveform_mode = 3'h0;
    rst = 1'b1;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    rd(8'h01, 8'h00);
    $display("reset test done");
    wr(8'h07, 8'h0f);
    rd(8'h06, 8'h0f);
    wr(8'h06, 8'h05);
    rd(8'h07, 8'h0a);
    wr(8'h06, 8'h0a);
    rd(8'h06, 8'h00);
    $display("set clear test done");
    @(posedge core_clk) timer_enable <= 1'b1;
    wr(8'h05, 8'h02);
    for (int n = 0; n < 8; n += 2) begin
      wr(8'h37 + n[7:0], 8'h12);
      wr(8'h36 + n[7:0], 8'h34 + n[8:1]);
    end
    rd(8'h06, 8'h0f);
    strobe(1'b0, 1'b1);
    chk(period_reg, 16'hffff);
    wr(8'h04, 8'h02);
    strobe(1'b0, 1'b1);
    chk(period_reg, 16'h1234);
    chk(compare_values, 48'h1237_1236_1235);
    rd(8'h06, 8'h00);
    rd(8'h26, 8'h34);
    rd(8'h27, 8'h12);
    $display("buffer test done");
    wr(8'h0f, 8'ha5);
    rd(8'h0f, 8'ha5);
    wr(8'h27, 8'h00);
    wr(8'h26, 8'h40);
    strobe(1'b0, 1'b0);
    chk(period_reg, 16'h0040);
    $display("latch test done");
    setcnt(16'h0010);
    wr(8'h05, 8'h01);
    strobe(1'b1, 1'b0);
    chk(count_reg, 16'h000f);
    wr(8'h04, 8'h01);
    strobe(1'b1, 1'b0);
    chk(count_reg, 16'h0010);
    $display("direction test done");
    foreach (row[i]) begin
      wr(8'h09, {5'h00, row[i][7:5]});
      level_req <= row[i][4];
      repeat (3) strobe(1'b0, 1'b0);
      strobe(row[i][3], 1'b0);
      cnt = cnt + {{14{row[i][1]}}, row[i][1:0]};
      chk(count_reg, cnt);
    end
    $display("event test done");
    wr(8'h09, 8'h00);
    debug_break <= 1'b1;
    strobe(1'b1, 1'b0);
    chk(count_reg, cnt);
    wr(8'h0e, 8'h01);
    strobe(1'b1, 1'b0);
    cnt = cnt + 16'h0001;
    chk(count_reg, cnt);
    @(posedge core_clk) debug_break <= 1'b0;
    $display("debug test done");
    wr(8'h29, 8'h00);
    wr(8'h28, cnt[7:0] + 8'h01);
    wr(8'h0a, 8'h10);
    wr(8'h0b, 8'h71);
    rd(8'h0b, 8'h00);
    strobe(1'b1, 1'b0);
    rd(8'h0b, 8'h10);
    chk(compare_irq, 3'h1);
    strobe(1'b1, 1'b0);
    rd(8'h0b, 8'h10);
    wr(8'h0b, 8'h10);
    rd(8'h0b, 8'h00);
    $display("compare test done");
    setcnt(16'h0040);
    strobe(1'b1, 1'b0);
    rd(8'h0b, 8'h01);
    chk(wrap_irq, 1'b0);
    wr(8'h0a, 8'h01);
    strobe(1'b1, 1'b0);
    chk(wrap_irq, 1'b1);
    wr(8'h0b, 8'h01);
    rd(8'h0b, 8'h00);
    chk(wrap_irq, 1'b0);
    $display("wrap test done");
    @(posedge core_clk) waveform_mode <= 3'h7;
    setcnt(16'h0040);
    strobe(1'b1, 1'b0);
    rd(8'h0b, 8'h00);
    rd(8'h04, 8'h01);
    setcnt(16'h0000);
    strobe(1'b1, 1'b0);
    rd(8'h0b, 8'h01);
    rd(8'h05, 8'h00);
    $display("dual slope test done");
    tally_and_finish;
  end
endmodule // timer_buffer_event_irq_ctrl_tb_top
`default_nettype wire
